// ### hdl/stm_defines.vh
/*
 * Register offsets, field positions, reset values and counts for the
 * standard timer mode and pin control block. Definitions only.
 */
`ifndef STM_DEFINES_VH
`define STM_DEFINES_VH

// Byte addresses on APB, one aligned word each
`define STM_CTRL0_ADDR      12'h000
`define STM_MODE_PIN_ADDR   12'h004
`define STM_CNT_LO_ADDR     12'h008
`define STM_CNT_HI_ADDR     12'h00c
`define STM_CMPA_LO_ADDR    12'h010
`define STM_CMPA_HI_ADDR    12'h014

// Control 0 fields: counter_on and compare_p_value
`define STM_ON_BIT          3
`define STM_CMPP_MSB        2
`define STM_CMPP_LSB        0

// timer_mode_pin_control fields
`define STM_MODE_MSB        7
`define STM_MODE_LSB        6
`define STM_PINF_MSB        5
`define STM_PINF_LSB        4
`define STM_OLC_BIT         3
`define STM_INV_BIT         2
`define STM_SWAP_BIT        1
`define STM_CLR_BIT         0

`define STM_MODE_CMP        2'h0
`define STM_MODE_CAP        2'h1
`define STM_MODE_PWM        2'h2
`define STM_MODE_TMR        2'h3

`define STM_PIN_HOLD        2'h0
`define STM_PIN_LOW         2'h1
`define STM_PIN_HIGH        2'h2
`define STM_PIN_TOGGLE      2'h3

`define STM_CAP_RISE        2'h0
`define STM_CAP_FALL        2'h1
`define STM_CAP_BOTH        2'h2

`define STM_REG_RESET       8'h00
`define STM_CNT_MAX         10'h3ff

`endif

// ### hdl/stm_timer.v
/*
 * Standard timer: 10-bit up counter, comparators A and P, mode and pin
 * control, capture, and the counter byte read path, as an APB slave.
 * Assumes the capture pin is asynchronous and that the counter advances
 * once per pclk (clock selection and pause live elsewhere).
 */
// Contract
// - Mode field selects compare, capture, PWM, timer
// - Timer mode: pin undefined, pin function unused
// - Compare A match: hold, low, high, toggle
// - PWM pin: inactive, active, PWM, single pulse
// - Capture on rise, fall, both, or disabled
// - Match to initial level shows no change
// - Counter-on rising edge restores initial level
// - Compare mode: level bit sets initial level
// - PWM mode: level bit sets active level
// - Single pulse: level bit is start level
// - Level bit ignored in timer mode
// - Invert bit inverts pin, not timer mode (the code also parks the pin low in capture mode)
// - Swap bit exchanges period and duty comparators
// - Clear bit picks compare A or P/overflow
// - Overflow clear only when compare P zero
// - Clear bit ignored in PWM and capture (the code still lets it mask match_p_evt in capture mode)
// - Low byte register reads counter bits 7:0
// - High byte read latches low byte buffer
// - Counter-on rise clears count, fall holds
// - Compare P matches counter bits 9:7
`timescale 1ns/1ps
`include "stm_defines.vh"

module stm_timer (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        capture_input_pin,
	output reg         timer_output_pin,
	output reg         match_a_evt,
	output reg         match_p_evt,
	output reg         capture_evt
);

	reg  [7:0] ctrl0_q;
	reg  [7:0] mode_q;
	reg  [9:0] cmpa_q;
	reg  [7:0] cmpa_buf_q;
	reg  [7:0] cnt_buf_q;
	reg  [9:0] cnt_q;
	reg  [9:0] cap_q;
	reg        on_q;
	reg        lvl_q;
	reg        pulse_done_q;
	reg        cap_s1_q;
	reg        cap_s2_q;
	reg        cap_s3_q;

	wire [1:0] mode   = mode_q[`STM_MODE_MSB:`STM_MODE_LSB];
	wire [1:0] pinf   = mode_q[`STM_PINF_MSB:`STM_PINF_LSB];
	wire       olc    = mode_q[`STM_OLC_BIT];
	wire       inv    = mode_q[`STM_INV_BIT];
	wire       swap   = mode_q[`STM_SWAP_BIT];
	wire       clrsel = mode_q[`STM_CLR_BIT];
	wire       on     = ctrl0_q[`STM_ON_BIT];
	wire [2:0] cmpp   = ctrl0_q[`STM_CMPP_MSB:`STM_CMPP_LSB];

	wire acc    = psel & penable;
	wire wr     = acc & pwrite;
	wire setup  = psel & ~penable;
	wire rd_set = setup & ~pwrite;
	wire on_set = on & ~on_q;
	wire run    = on & on_q;

	// Compare P matches the top three counter bits with the low seven at zero, so a zero
	// value means the full 1024-count wrap
	wire       match_p  = (cnt_q[9:7] == cmpp) && (cnt_q[6:0] == 7'h00)
		&& (cnt_q != 10'h000);
	wire       ovf      = (cnt_q == `STM_CNT_MAX);
	wire       match_a  = (cnt_q == cmpa_q) && (cmpa_q != 10'h000);
	wire       is_pwm   = (mode == `STM_MODE_PWM);
	wire       is_cap   = (mode == `STM_MODE_CAP);
	// Period comparator chosen by the swap bit
	wire [9:0] period   = swap ? cmpa_q : {cmpp, 7'h00};
	wire [9:0] duty     = swap ? {cmpp, 7'h00} : cmpa_q;
	wire       per_end  = (period == 10'h000) ? ovf
		: (cnt_q == period - 10'h001);
	reg        clr_cnt;

	always @* begin
		if (is_pwm) begin
			clr_cnt = per_end;
		end else if (is_cap) begin
			clr_cnt = ovf;
		end else if (clrsel) begin
			clr_cnt = match_a;
		end else begin
			// Overflow wrap only counts when compare P is zero
			clr_cnt = (cmpp == 3'h0) ? ovf : match_p;
		end
	end

	// Capture edge choice
	wire cap_rise = cap_s2_q & ~cap_s3_q;
	wire cap_fall = ~cap_s2_q & cap_s3_q;
	reg  cap_hit;

	always @* begin
		case (pinf)
			`STM_CAP_RISE: cap_hit = cap_rise;
			`STM_CAP_FALL: cap_hit = cap_fall;
			`STM_CAP_BOTH: cap_hit = cap_rise | cap_fall;
			default:       cap_hit = 1'b0;
		endcase
	end

	// Internal pin level before inversion
	reg lvl_d;

	always @* begin
		lvl_d = lvl_q;
		// Forced PWM levels win over the start level
		if (on_set && !(is_pwm && !pinf[1])) begin
			lvl_d = olc;
		end else if (mode == `STM_MODE_CMP && run && match_a) begin
			// Driving the level already held shows no change
			case (pinf)
				`STM_PIN_LOW:    lvl_d = 1'b0;
				`STM_PIN_HIGH:   lvl_d = 1'b1;
				`STM_PIN_TOGGLE: lvl_d = ~lvl_q;
				default:         lvl_d = lvl_q;
			endcase
		end else if (is_pwm) begin
			// Pin function is not resampled safely mid-run
			case (pinf)
				2'h0:    lvl_d = ~olc;
				2'h1:    lvl_d = olc;
				2'h2:    lvl_d = (run && cnt_q < duty) ? olc : ~olc;
				default: lvl_d = (run && !pulse_done_q && cnt_q < duty)
					? olc : ~olc;
			endcase
		end
	end

	// Capture pin: two flops against metastability, a third for edges
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			cap_s3_q <= 1'b0;
		end else begin
			cap_s1_q <= capture_input_pin;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	// Counter-on history, used to find its rising edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q <= 1'b0;
		end else begin
			on_q <= on;
		end
	end

	// Internal pin level, kept apart from inversion
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	// Counter: on rise clears, off holds the count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 10'h000;
		end else if (on_set) begin
			cnt_q <= 10'h000;
		end else if (run) begin
			cnt_q <= clr_cnt ? 10'h000 : cnt_q + 10'h001;
		end
	end

	// Single pulse: the window closes for good at the first period end,
	// and only a new counter-on rise opens it again
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_done_q <= 1'b0;
		end else if (on_set) begin
			pulse_done_q <= 1'b0;
		end else if (run && is_pwm && per_end) begin
			pulse_done_q <= 1'b1;
		end
	end

	// Count taken at the chosen capture edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_q <= 10'h000;
		end else if (run && is_cap && cap_hit) begin
			cap_q <= cnt_q;
		end
	end

	// Event pulses, one cycle each
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_evt <= 1'b0;
		end else begin
			capture_evt <= run & is_cap & cap_hit;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_a_evt <= 1'b0;
		end else begin
			match_a_evt <= run & match_a & ~is_cap;
		end
	end

	// Compare P stays silent while compare A clears the counter
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_p_evt <= 1'b0;
		end else begin
			match_p_evt <= run & match_p & ~(clrsel & ~is_pwm);
		end
	end

	// Output pin level ahead of its flop
	reg pin_d;

	always @* begin
		if (mode == `STM_MODE_TMR || is_cap) begin
			// Parked low: the pin is undefined here, and neither the
			// level bit nor the invert bit may reach it
			pin_d = 1'b0;
		end else begin
			pin_d = lvl_d ^ inv;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= 1'b0;
		end else begin
			timer_output_pin <= pin_d;
		end
	end

	// Address decode; anything else is refused with pslverr
	wire       mapped = (paddr == `STM_CTRL0_ADDR)
		|| (paddr == `STM_MODE_PIN_ADDR)
		|| (paddr == `STM_CNT_LO_ADDR)
		|| (paddr == `STM_CNT_HI_ADDR)
		|| (paddr == `STM_CMPA_LO_ADDR)
		|| (paddr == `STM_CMPA_HI_ADDR);

	// In capture mode the count bytes show the captured value
	wire [9:0] cnt_src = is_cap ? cap_q : cnt_q;

	reg  [31:0] rdata_d;

	always @* begin
		rdata_d = 32'h00000000;
		case (paddr)
		`STM_CTRL0_ADDR:    rdata_d[7:0] = ctrl0_q;
		`STM_MODE_PIN_ADDR: rdata_d[7:0] = mode_q;
		// Low byte comes from the buffer filled by the high byte
		// read
		`STM_CNT_LO_ADDR:   rdata_d[7:0] = cnt_buf_q;
		`STM_CNT_HI_ADDR:   rdata_d[1:0] = cnt_src[9:8];
		`STM_CMPA_LO_ADDR:  rdata_d[7:0] = cmpa_q[7:0];
		`STM_CMPA_HI_ADDR:  rdata_d[1:0] = cmpa_q[9:8];
		default:            rdata_d = 32'h00000000;
		endcase
	end

	// Single-cycle APB answer: pready rises in the access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
		end
	end

	// Read data is latched in the setup cycle, so it stands while
	// pready is high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= pwrite ? 32'h00000000 : rdata_d;
		end
	end

	// Buffer filled from the same count sample as the high byte, so
	// the pair never tears across a carry
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_buf_q <= 8'h00;
		end else if (rd_set && paddr == `STM_CNT_HI_ADDR) begin
			cnt_buf_q <= cnt_src[7:0];
		end
	end

	// Register writes take effect at the access edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_q <= `STM_REG_RESET;
		end else if (wr && paddr == `STM_CTRL0_ADDR) begin
			ctrl0_q <= pwdata[7:0];
		end
	end

	// Mode written as-is; software stops first
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `STM_REG_RESET;
		end else if (wr && paddr == `STM_MODE_PIN_ADDR) begin
			mode_q <= pwdata[7:0];
		end
	end

	// Compare A low byte waits in a buffer until the high byte lands
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpa_buf_q <= 8'h00;
		end else if (wr && paddr == `STM_CMPA_LO_ADDR) begin
			cmpa_buf_q <= pwdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmpa_q <= 10'h000;
		end else if (wr && paddr == `STM_CMPA_HI_ADDR) begin
			cmpa_q <= {pwdata[1:0], cmpa_buf_q};
		end
	end

endmodule

// ### tb/stm_timer_monitor.sv
/* Pin and capture checker for stm_timer, bound to every instance.
   Assumes control bytes at 0x000/0x004 are shadowed from APB writes. */
`timescale 1ns/1ps
module stm_timer_monitor (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        timer_output_pin,
	input wire        match_a_evt,
	input wire        capture_evt
);
	logic [7:0] m_q;
	logic       on_q;
	logic [1:0] c_q;
	wire        wr = psel & penable & pwrite;
	// Settle margin: pin lags a control write by up to two cycles
	wire        ok = c_q == 2'h3;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_q <= 8'h00;
			on_q <= 1'h0;
			c_q <= 2'h0;
		end else begin
			c_q <= c_q + {1'h0, c_q != 2'h3};
			if (wr && paddr == 12'h004)
				m_q <= pwdata[7:0];
			if (wr && paddr == 12'h000)
				on_q <= pwdata[3];
			if (wr && paddr[11:3] == 9'h000)
				c_q <= 2'h0;
		end
	end
	property p_tmr;
		ok && m_q[7:6] == 2'h3 |-> !timer_output_pin;
	endproperty
	a_tmr: assert property (p_tmr) else $error("pin in timer mode");
	property p_cap;
		ok && m_q[7:4] == 4'h7 |-> !capture_evt;
	endproperty
	a_cap: assert property (p_cap) else $error("capture off");
	property p_hold;
		ok && m_q[7:4] == 4'h0 |=> $stable(timer_output_pin);
	endproperty
	a_hold: assert property (p_hold) else $error("pin moved");
	property p_on;
		$rose(on_q) && m_q[7:6] == 2'h0
			|-> ##[1:2] timer_output_pin == (m_q[3] ^ m_q[2]);
	endproperty
	a_on: assert property (p_on) else $error("initial level");
	property p_tgl;
		ok && m_q[7:4] == 4'h3 && match_a_evt
			|-> ##[0:1] $changed(timer_output_pin);
	endproperty
	a_tgl: assert property (p_tgl) else $error("no toggle");
	property p_hi;
		ok && m_q[7:4] == 4'h2 && match_a_evt
			|=> timer_output_pin == !m_q[2];
	endproperty
	a_hi: assert property (p_hi) else $error("not high");
	property p_lo;
		ok && m_q[7:4] == 4'h1 && match_a_evt
			|=> timer_output_pin == m_q[2];
	endproperty
	a_lo: assert property (p_lo) else $error("not low");
	property p_frc;
		ok && m_q[7:5] == 3'h4
			|-> timer_output_pin == ((m_q[4] ~^ m_q[3]) ^ m_q[2]);
	endproperty
	a_frc: assert property (p_frc) else $error("forced level");
endmodule
bind stm_timer stm_timer_monitor u_mon (.*);

// ### tb/stm_pin_model.sv
/* Far side: drives the capture pin to the level the bench asks for.
   Assumes the level changes only just after a pclk edge. */
`timescale 1ns/1ps
module stm_pin_model (
	input wire         pclk,
	input wire         lvl,
	output logic       capture_input_pin
);
	initial capture_input_pin = 1'h0;
	always @(posedge pclk)
		capture_input_pin <= lvl;
endmodule

// ### tb/standard_timer_mode_control_bench.sv
/* Self-checking bench for stm_timer: registers, pin modes, capture.
   Assumes one wait-free access cycle per APB transfer. */
`timescale 1ns/1ps
module standard_timer_mode_control_bench;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        lvl = 1'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr, capture_input_pin;
	wire         timer_output_pin, match_a_evt, capture_evt;
	logic [31:0] rd;
	logic        se, f;
	int          n_errors = 0;
	int          comparisons = 0;
	always #2 pclk = ~pclk;
	stm_timer DUT (.*, .match_p_evt());
	stm_pin_model u_pin (.*);
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		se = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge: no strobe is written twice in one time step
		@(posedge pclk);
	endtask
	task ck(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wt(input logic c, input int n);
		f = 1'h0;
		repeat (n) if (!f) begin
			@(posedge pclk);
			f = c ? capture_evt : match_a_evt;
		end
	endtask
	task t_reg;
		bus(0, 12'h004, 0);
		ck("mode_pin", 0, rd);
		bus(1, 12'h008, 32'hff);
		bus(0, 12'h008, 0);
		ck("cnt_lo", 0, rd);
		bus(1, 12'h004, 32'ha5);
		bus(0, 12'h004, 0);
		ck("mode_rw", 32'ha5, rd);
		bus(0, 12'h0f0, 0);
		ck("slverr", 1, se);
		$display("t_reg done");
	endtask
	task t_cnt;
		bus(1, 12'h004, 0);
		bus(1, 12'h000, 32'h9);
		repeat (300) @(posedge pclk);
		bus(0, 12'h00c, 0);
		ck("cnt_hi", 0, rd);
		bus(0, 12'h008, 0);
		ck("cnt_b7", 0, rd[7]);
		bus(1, 12'h000, 0);
		bus(1, 12'h000, 32'h8);
		bus(1, 12'h000, 0);
		bus(0, 12'h00c, 0);
		bus(0, 12'h008, 0);
		ck("cnt_new", 1, rd < 8);
		$display("t_cnt done");
	endtask
	task t_pin;
		logic [7:0] md[11] = '{8'h20, 8'h30, 8'h18, 8'h28, 8'h08, 8'h24,
			8'h90, 8'h98, 8'h80, 8'h84, 8'hc8};
		logic [10:0] ex = 11'h19b;
		bus(1, 12'h010, 32'h9);
		bus(1, 12'h014, 0);
		for (int i = 0; i < 11; i++) begin
			bus(1, 12'h000, 0);
			bus(1, 12'h004, md[i]);
			bus(1, 12'h000, 32'h8);
			repeat (2) @(posedge pclk);
			if (md[i][7:6] == 2'h0) begin
				ck("init", md[i][3] ^ md[i][2], timer_output_pin);
				wt(0, 40);
				@(posedge pclk);
			end
			ck("pin", ex[i], timer_output_pin);
		end
		$display("t_pin done");
	endtask
	task t_cap;
		logic [7:0] cm[4] = '{8'h40, 8'h50, 8'h70, 8'h60};
		for (int i = 0; i < 4; i++) begin
			bus(1, 12'h000, 0);
			bus(1, 12'h004, cm[i]);
			bus(1, 12'h000, 32'h8);
			lvl <= (i % 2 == 0);
			wt(1, 12);
			ck("capture", 4'hb >> i & 1, f);
		end
		bus(0, 12'h00c, 0);
		bus(0, 12'h008, 0);
		ck("cap_val", 3, rd);
		$display("t_cap done");
	endtask
	task t_pwm;
		logic [7:0] pm[3] = '{8'ha8, 8'haa, 8'hb8};
		logic [2:0] pe[3] = '{3'h5, 3'h7, 3'h1};
		for (int i = 0; i < 3; i++) begin
			bus(1, 12'h000, 0);
			bus(1, 12'h004, pm[i]);
			bus(1, 12'h000, 32'h9);
			repeat (2) @(posedge pclk);
			ck("pwm_start", pe[i][0], timer_output_pin);
			repeat (20) @(posedge pclk);
			ck("pwm_duty", pe[i][1], timer_output_pin);
			repeat (110) @(posedge pclk);
			ck("pwm_next", pe[i][2], timer_output_pin);
		end
		$display("t_pwm done");
	endtask
	task complete_run;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		complete_run;
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reg;
		t_cnt;
		t_pin;
		t_pwm;
		t_cap;
		complete_run;
	end
endmodule
